// >>> src/fios_pkg.sv
/*
  fios_pkg: register map, field layouts, reset values and timing
  constants for the field I/O supervisor.
  assumes a 125 MHz core clock and an 8-bit converter scaled to 36.3 V.
*/
package fios_pkg;
  // ************************************************************
  // register byte offsets (one aligned 32-bit word each)
  // ************************************************************
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_OUTPUTS   = 8'h08;
  localparam logic [7:0] OFS_INPUTS    = 8'h0c;
  localparam logic [7:0] OFS_ANALOG    = 8'h10;
  localparam logic [7:0] OFS_FIELD     = 8'h14;
  localparam logic [7:0] OFS_ENCODERS  = 8'h18;
  localparam logic [7:0] OFS_WDOG_WORK = 8'h1c;
  localparam logic [7:0] OFS_WDOG_NV   = 8'h20;
  localparam logic [7:0] OFS_BAUD_NV   = 8'h24;
  localparam logic [7:0] OFS_UNIT_WORK = 8'h28;
  localparam logic [7:0] OFS_UNIT_NV   = 8'h2c;
  localparam logic [7:0] OFS_DRV_FAULT = 8'h30;
  localparam logic [7:0] OFS_BAUD_WORK = 8'h34;
  // ************************************************************
  // control and status bit positions
  // ************************************************************
  localparam int CTRL_MODE_LO   = 0;
  localparam int CTRL_SETUP     = 2;
  localparam int CTRL_CLR_FAULT = 3;
  localparam int ST_FAULT       = 0;
  localparam int ST_FIELD_LOSS  = 1;
  localparam int ST_SHORT       = 2;
  localparam int ST_OVERTEMP    = 3;
  // ************************************************************
  // modes, reset values and scaling
  // ************************************************************
  typedef enum logic [1:0] {FIOS_MODE_IO, FIOS_MODE_ANALOG, FIOS_MODE_ENC} fios_mode_t;
  localparam logic [15:0] WDOG_DEFAULT_MS = 16'h0032;   // 50 ms
  localparam logic [3:0]  BAUD_DEFAULT    = 4'h9;       // 2.5 Mbaud
  localparam logic [3:0]  BAUD_MAX_INDEX  = 4'hb;
  localparam logic [31:0] UNIT_DEFAULT    = 32'h00000000; // arbitrary neutral value
  localparam int FULL_SCALE_MV = 36300;
  localparam int ENC_THR_MV    = 2500;
  localparam int FIELD_MIN_MV  = 5000;
  localparam int CODE_SPAN     = 256;
  localparam logic [7:0] ENC_THR_CODE   = 8'((ENC_THR_MV * CODE_SPAN) / FULL_SCALE_MV);
  localparam logic [7:0] FIELD_MIN_CODE = 8'((FIELD_MIN_MV * CODE_SPAN) / FULL_SCALE_MV);
  localparam logic [3:0] THR_HIGH_PCT10 = 4'h6;          // 60 percent, in tenths
  localparam logic [3:0] THR_LOW_PCT10  = 4'h4;          // 40 percent, in tenths
  localparam logic [3:0] TENTHS         = 4'ha;
  localparam logic [5:0] FIELD_CHAN     = 6'h20;
  localparam int CLK_MHZ   = 125;
  localparam int MS_CYCLES = CLK_MHZ * 1000;
  localparam logic [9:0] BLINK_EXCHANGES = 10'h1f4;      // 500 exchanges per toggle
  // frame sizes in bytes per mode
  localparam logic [3:0] FRAME_OUT_BYTES = 4'h2;
  localparam logic [3:0] FRAME_IN_IO     = 4'h4;
  localparam logic [3:0] FRAME_IN_ANALOG = 4'h9;
  localparam logic [3:0] FRAME_IN_ENC    = 4'hc;
  // link rates per baud index
  localparam logic [23:0] BAUD_TABLE [12] = '{
    24'd9600, 24'd19200, 24'd38400, 24'd57600, 24'd115200, 24'd230400,
    24'd460800, 24'd921600, 24'd1250000, 24'd2500000, 24'd5000000, 24'd10000000};
endpackage

// >>> src/fios_top.sv
/* fios_top: supervision logic of an isolated 32-in / 16-out field I/O card: input sensing,
   analog capture, quadrature counters, field monitoring, watchdog, parameters, lamps and
   process data mode, reached over an Avalon-MM slave. assumes converter results arrive on
   core_clk; driver fault pins are asynchronous and are synchronised here. */
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module fios_top
  import fios_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES,
  parameter int N_OUT       = 16,
  parameter int N_GROUP     = 2
) (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // avalon-mm slave
  input  wire logic [7:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // converter results, channel 32 is the field supply
  input  wire logic              adc_valid,
  input  wire logic [5:0]        adc_chan,
  input  wire logic [7:0]        adc_code,
  // driver fault pins
  input  wire logic [N_OUT-1:0]  short_det,
  input  wire logic [N_GROUP-1:0] overtemp_warn,
  // field side
  output logic      [N_OUT-1:0]  field_out,
  output logic                   fault_led,
  output logic                   activity_led,
  output logic      [23:0]       baud_rate,
  output logic      [3:0]        frame_in_bytes,
  output logic      [3:0]        frame_out_bytes
);
  localparam int GROUP_W = N_OUT / N_GROUP;
  // two flops on the driver fault pins before anything reads them
  logic [N_OUT-1:0]   short_s1_q, short_s2_q;
  logic [N_GROUP-1:0] ot_s1_q, ot_s2_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      short_s1_q <= '0;
      short_s2_q <= '0;
      ot_s1_q    <= '0;
      ot_s2_q    <= '0;
    end else begin
      short_s1_q <= short_det;
      short_s2_q <= short_s1_q;
      ot_s1_q    <= overtemp_warn;
      ot_s2_q    <= ot_s1_q;
    end
  end
  // ************************************************************
  // register file state
  // ************************************************************
  logic [1:0]         mode_q;
  logic [15:0]        out_req_q, wdog_work_q, wdog_nv_q;
  logic [3:0]         baud_nv_q, baud_work_q;
  logic [31:0]        unit_work_q, unit_nv_q, rd_d;
  logic [N_OUT-1:0]   short_lat_q;
  logic [N_GROUP-1:0] ot_lat_q;
  logic               setup_q, load_pend_q, fault_q, wr_ok, exchange, clr_fault;
  // a request completes at the edge where waitrequest is seen low
  assign wr_ok     = avs_write && !avs_waitrequest;
  assign exchange  = wr_ok && (avs_address == OFS_OUTPUTS);
  assign clr_fault = wr_ok && (avs_address == OFS_CTRL) && avs_byteenable[0]
                     && avs_writedata[CTRL_CLR_FAULT];
  // one wait cycle: readdata is latched while waitrequest drops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= rd_d;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end
  // control: mode, setup; mode 3 is not a mode and is refused
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q  <= FIOS_MODE_IO;
      setup_q <= 1'b0;
    end else if (wr_ok && avs_address == OFS_CTRL && avs_byteenable[0]) begin
      if (avs_writedata[CTRL_MODE_LO +: 2] != 2'h3) begin
        mode_q <= avs_writedata[CTRL_MODE_LO +: 2];
      end
      setup_q <= avs_writedata[CTRL_SETUP];
    end
  end
  // output request word; while faulted the setting is dropped
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_req_q <= '0;
    end else if (fault_q) begin
      out_req_q <= '0;
    end else if (exchange) begin
      if (avs_byteenable[0]) out_req_q[7:0]  <= avs_writedata[7:0];
      if (avs_byteenable[1]) out_req_q[15:8] <= avs_writedata[15:8];
    end
  end
  // persistent parameters: flops standing in for the eeprom, lost with logic power
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wdog_nv_q <= WDOG_DEFAULT_MS;
      baud_nv_q <= BAUD_DEFAULT;
      unit_nv_q <= UNIT_DEFAULT;
    end else if (wr_ok) begin
      if (avs_address == OFS_WDOG_NV && avs_byteenable[1:0] == 2'h3) begin
        wdog_nv_q <= avs_writedata[15:0];
      end
      if (avs_address == OFS_BAUD_NV && avs_byteenable[0]
          && avs_writedata[3:0] <= BAUD_MAX_INDEX) begin
        baud_nv_q <= avs_writedata[3:0];
      end
      if (avs_address == OFS_UNIT_NV && avs_byteenable == 4'hf) begin
        unit_nv_q <= avs_writedata;
      end
    end
  end
  // working parameters, loaded from persistent ones once after reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      load_pend_q <= 1'b1;
      wdog_work_q <= WDOG_DEFAULT_MS;
      baud_work_q <= BAUD_DEFAULT;
      unit_work_q <= UNIT_DEFAULT;
    end else if (load_pend_q) begin
      load_pend_q <= 1'b0;
      wdog_work_q <= wdog_nv_q;
      baud_work_q <= baud_nv_q;
      unit_work_q <= unit_nv_q;
    end else if (wr_ok) begin
      if (avs_address == OFS_WDOG_WORK && avs_byteenable[1:0] == 2'h3) begin
        wdog_work_q <= avs_writedata[15:0];
      end
      if (avs_address == OFS_UNIT_WORK && avs_byteenable == 4'hf) begin
        unit_work_q <= avs_writedata;
      end
    end
  end
  // ************************************************************
  // input sensing and analog capture
  // ************************************************************
  logic [31:0] in_q;
  logic [7:0]  ana_q [4];
  logic [7:0]  field_code_q;
  logic [11:0] code_x10, fld_hi, fld_lo;
  // scaled by ten, so the 60 and 40 percent marks need no divider
  assign code_x10 = adc_code * TENTHS;
  assign fld_hi   = field_code_q * THR_HIGH_PCT10;
  assign fld_lo   = field_code_q * THR_LOW_PCT10;
  // hysteresis against field voltage; encoder inputs use a fixed level
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_q <= '0;
    end else if (adc_valid && !adc_chan[5]) begin
      if (mode_q == FIOS_MODE_ENC && adc_chan[4:2] == 3'h4) begin
        in_q[adc_chan[4:0]] <= (adc_code >= ENC_THR_CODE);
      end else if (code_x10 > fld_hi) begin
        in_q[adc_chan[4:0]] <= 1'b1;
      end else if (code_x10 < fld_lo) begin
        in_q[adc_chan[4:0]] <= 1'b0;
      end
    end
  end
  // raw codes for inputs 0..3 and the field supply
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ana_q        <= '{default: 8'h00};
      field_code_q <= '0;
    end else if (adc_valid) begin
      if (adc_chan[5:2] == 4'h0) ana_q[adc_chan[1:0]] <= adc_code;
      if (adc_chan == FIELD_CHAN) field_code_q <= adc_code;
    end
  end
  // quadrature counters: one count per cycle on the A rising edge
  logic [3:0]  enc_prev_q;
  logic [15:0] enc_cnt_q [2];
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      enc_prev_q <= '0;
    end else begin
      enc_prev_q <= in_q[19:16];
    end
  end
  for (genvar e = 0; e < 2; e++) begin : g_enc
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        enc_cnt_q[e] <= '0;
      end else if (mode_q == FIOS_MODE_ENC && in_q[16+2*e] && !enc_prev_q[2*e]) begin
        enc_cnt_q[e] <= in_q[17+2*e] ? enc_cnt_q[e] - 16'h0001
                                     : enc_cnt_q[e] + 16'h0001;
      end
    end
  end
  // watchdog and fault flag
  logic [$clog2(MS_CYCLES_P)-1:0] ms_cnt_q;
  logic [15:0] wd_ms_q;
  logic        ms_tick, wd_bite;
  // a zero period never bites; the elapsed count saturates rather than wrapping
  assign ms_tick = (ms_cnt_q == ($clog2(MS_CYCLES_P))'(MS_CYCLES_P - 1));
  assign wd_bite = (wdog_work_q != '0) && (wd_ms_q >= wdog_work_q);
  // millisecond prescaler and elapsed time since the last exchange
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_q <= '0;
      wd_ms_q  <= '0;
    end else begin
      ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
      if (exchange) begin
        wd_ms_q <= '0;
      end else if (ms_tick && wd_ms_q != 16'hffff) begin
        wd_ms_q <= wd_ms_q + 16'h0001;
      end
    end
  end
  // sticky fault: a bite in the clearing cycle wins over the clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_q <= 1'b1;
    end else if (wd_bite && !exchange) begin
      fault_q <= 1'b1;
    end else if (clr_fault) begin
      fault_q <= 1'b0;
    end
  end
  // driver protection latches, cleared with the fault clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      short_lat_q <= '0;
      ot_lat_q    <= '0;
    end else begin
      short_lat_q <= short_s2_q | (clr_fault ? '0 : short_lat_q);
      ot_lat_q    <= ot_s2_q | (clr_fault ? '0 : ot_lat_q);
    end
  end
  // ************************************************************
  // field outputs, indicators and link settings
  // ************************************************************
  logic [N_OUT-1:0] grp_off;
  logic [9:0]       blink_q;
  for (genvar g = 0; g < N_GROUP; g++) begin : g_grp
    assign grp_off[g*GROUP_W +: GROUP_W] = {GROUP_W{ot_lat_q[g]}};
  end
  // fault, shorted outputs and hot driver groups all gate the requested word
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      field_out <= '0;
    end else begin
      field_out <= fault_q ? '0 : (out_req_q & ~short_lat_q & ~grp_off);
    end
  end
  // activity toggles every 500 exchanges: 1 Hz blink at 1 kHz updates
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      blink_q      <= '0;
      activity_led <= 1'b0;
      fault_led    <= 1'b1;
    end else begin
      if (exchange) begin
        blink_q <= (blink_q == BLINK_EXCHANGES - 10'h001) ? '0 : blink_q + 10'h001;
      end
      if (setup_q) begin
        activity_led <= 1'b1;
      end else if (exchange && blink_q == BLINK_EXCHANGES - 10'h001) begin
        activity_led <= !activity_led;
      end
      fault_led <= fault_q || setup_q || (|short_lat_q) || (|ot_lat_q);
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      baud_rate       <= BAUD_TABLE[BAUD_DEFAULT];
      frame_in_bytes  <= FRAME_IN_IO;
      frame_out_bytes <= FRAME_OUT_BYTES;
    end else begin
      baud_rate       <= BAUD_TABLE[baud_work_q];
      frame_out_bytes <= FRAME_OUT_BYTES;
      case (mode_q)
        FIOS_MODE_IO:     frame_in_bytes <= FRAME_IN_IO;
        FIOS_MODE_ANALOG: frame_in_bytes <= FRAME_IN_ANALOG;
        FIOS_MODE_ENC:    frame_in_bytes <= FRAME_IN_ENC;
        default:          frame_in_bytes <= FRAME_IN_IO;
      endcase
    end
  end
  // read mux; analog words read zero in mode 0, unmapped reads zero
  always_comb begin
    rd_d = '0;
    case (avs_address)
      OFS_CTRL:      rd_d = {28'h0, 1'b0, setup_q, mode_q};
      OFS_STATUS:    rd_d = {28'h0, |ot_lat_q, |short_lat_q,
                             field_code_q < FIELD_MIN_CODE, fault_q};
      OFS_OUTPUTS:   rd_d = {16'h0, out_req_q};
      OFS_INPUTS:    rd_d = in_q;
      OFS_ANALOG:    rd_d = (mode_q == FIOS_MODE_IO) ? '0
                          : {ana_q[3], ana_q[2], ana_q[1], ana_q[0]};
      OFS_FIELD:     rd_d = (mode_q == FIOS_MODE_ANALOG) ? {24'h0, field_code_q} : '0;
      OFS_ENCODERS:  rd_d = (mode_q == FIOS_MODE_ENC) ? {enc_cnt_q[1], enc_cnt_q[0]} : '0;
      OFS_WDOG_WORK: rd_d = {16'h0, wdog_work_q};
      OFS_WDOG_NV:   rd_d = {16'h0, wdog_nv_q};
      OFS_BAUD_NV:   rd_d = {28'h0, baud_nv_q};
      OFS_UNIT_WORK: rd_d = unit_work_q;
      OFS_UNIT_NV:   rd_d = unit_nv_q;
      OFS_DRV_FAULT: rd_d = {14'h0, ot_lat_q, short_lat_q};
      OFS_BAUD_WORK: rd_d = {28'h0, baud_work_q};
      default:       rd_d = '0;
    endcase
  end
  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  fault_blocks_out_a: assert property (fault_q |=> field_out == '0)
    else $error("outputs driven while faulted");
  bite_sets_fault_a: assert property (wd_bite && !exchange |=> fault_q)
    else $error("watchdog bite did not set fault");
  wdog_off_zero_a: assert property (!fault_q && wdog_work_q == '0 |=> fault_q == 1'b0)
    else $error("fault set with the watchdog off");
  fault_sticky_a: assert property (fault_q && !clr_fault |=> fault_q)
    else $error("fault dropped without clear");
  exch_restart_a: assert property (exchange |=> wd_ms_q == '0)
    else $error("exchange did not restart watchdog");
  setup_leds_a: assert property (setup_q |=> fault_led && activity_led)
    else $error("setup lamps wrong");
  short_off_a: assert property (short_s2_q[0] |=> ##1 !field_out[0])
    else $error("shorted output still driven");
  ot_group_a: assert property (ot_s2_q[N_GROUP-1]
                               |=> ##1 field_out[N_OUT-1 -: GROUP_W] == '0)
    else $error("hot driver group still driven");
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
                               |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("slave answer timing wrong");
  frame_mode0_a: assert property ((mode_q == FIOS_MODE_IO) [*2]
                                  |-> frame_in_bytes == FRAME_IN_IO)
    else $error("mode 0 frame size wrong");
  clear_cov_c: cover property (fault_q ##1 clr_fault ##1 !fault_q);
  bite_cov_c:  cover property (!fault_q ##1 wd_bite ##1 fault_q);
  enc_cov_c:   cover property (mode_q == FIOS_MODE_ENC && in_q[16] && !enc_prev_q[0]);
endmodule

// >>> tb/fios_host_model.sv
/* fios_host_model: avalon-mm master in place of the host controller.
   assumes one clock; the bench timeout ends any wait. */
`timescale 1ns/1ps
module fios_host_model
  import fios_pkg::*;
(
  input  wire logic        core_clk,
  output logic      [7:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  // ************************************************************
  // bus cycles; the host controller's command and data side reduces to these
  // ************************************************************
  // idle bus from time zero
  initial begin
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hf;
  end
  // request held until waitrequest is seen low; output writes feed the watchdog
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_read      <= !w;
    avs_write     <= w;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // the host must clear the fault before outputs act
  task automatic clear_fault();
    logic [31:0] unused;
    xfer(1'b1, OFS_CTRL, 32'h8, unused);
  endtask
endmodule

// >>> tb/tb_isolated_field_io_supervisor.sv
/* tb_isolated_field_io_supervisor: register-level tests of fios_top.
   assumes MS_CYCLES_P = 10, so the 50 ms default watchdog is 500 cycles. */
`timescale 1ns/1ps
module tb_isolated_field_io_supervisor
  import fios_pkg::*;
;
  logic core_clk, reset_n, adc_valid, waitreq;
  logic [7:0] addr, adc_code;
  logic rd_s, wr_s;
  logic [31:0] wdata, rdata, d;
  logic [3:0] be, fin, fout;
  logic [5:0] adc_chan;
  logic [15:0] short_det, field_out;
  logic [1:0] overtemp_warn;
  logic fault_led, activity_led;
  logic [23:0] baud_rate;
  logic [3:0] fexp [4] = '{4'h4, 4'h9, 4'hc, 4'hc};
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  // ************************************************************
  // design, host and clock
  // ************************************************************
  fios_top #(.MS_CYCLES_P(10)) uut (.core_clk(core_clk), .reset_n(reset_n),
    .avs_address(addr), .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wdata),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(waitreq),
    .adc_valid(adc_valid), .adc_chan(adc_chan), .adc_code(adc_code),
    .short_det(short_det), .overtemp_warn(overtemp_warn), .field_out(field_out),
    .fault_led(fault_led), .activity_led(activity_led), .baud_rate(baud_rate),
    .frame_in_bytes(fin), .frame_out_bytes(fout));
  fios_host_model host (.core_clk(core_clk), .avs_address(addr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_writedata(wdata), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(waitreq));
  always #4 core_clk = ~core_clk;
  // hang guard, well above the roughly 3500 cycles of the tests
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic summarize();
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] unused;
    host.xfer(1'b1, a, v, unused);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, d);
    chk(d & m, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // one converter result, a single-cycle pulse
  task automatic adc(input logic [5:0] ch, input logic [7:0] code);
    @(posedge core_clk);
    adc_valid <= 1'b1;
    adc_chan  <= ch;
    adc_code  <= code;
    @(posedge core_clk);
    adc_valid <= 1'b0;
  endtask
  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    adc_valid = 1'b0;
    adc_chan = 6'h00;
    adc_code = 8'h00;
    short_det = 16'h0;
    overtemp_warn = 2'h0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    tick(2);
    chk({fault_led, activity_led}, 2'b10);
    chk(baud_rate, 24'd2500000);
    chk({fin, fout}, 8'h42);
    rdc(OFS_STATUS, 32'h1, 32'h1);
    wr(OFS_OUTPUTS, 32'h1234);
    rdc(OFS_OUTPUTS, 32'hffffffff, 32'h0);
    host.clear_fault();
    wr(OFS_OUTPUTS, 32'ha5a5);
    tick(2);
    chk(field_out, 16'ha5a5);
    chk(fault_led, 1'b0);
    // exchanges every 200 cycles keep a 500 cycle watchdog fed
    for (int i = 0; i < 3; i++) begin
      tick(200);
      wr(OFS_OUTPUTS, 32'ha5a5);
    end
    rdc(OFS_STATUS, 32'h1, 32'h0);
    tick(520);
    rdc(OFS_STATUS, 32'h1, 32'h1);
    chk(field_out, 16'h0);
    wr(OFS_WDOG_WORK, 32'h0);
    host.clear_fault();
    tick(700);
    rdc(OFS_STATUS, 32'h1, 32'h0);
    // five exchanges so far; the lamp toggles on exchange number BLINK_EXCHANGES
    for (int i = 5; i < BLINK_EXCHANGES - 1; i++) begin
      wr(OFS_OUTPUTS, 32'h0);
    end
    tick(1);
    chk(activity_led, 1'b0);
    wr(OFS_OUTPUTS, 32'h0);
    tick(1);
    chk(activity_led, 1'b1);
    rdc(OFS_WDOG_NV, 32'hffff, 32'h32);
    wr(OFS_BAUD_NV, 32'hc);
    rdc(OFS_BAUD_NV, 32'hf, 32'h9);
    wr(OFS_BAUD_NV, 32'h3);
    rdc(OFS_BAUD_WORK, 32'hf, 32'h9);
    chk(baud_rate, 24'd2500000);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_CTRL, 32'(m));
      tick(2);
      chk(fin, fexp[m]);
    end
    wr(OFS_CTRL, 32'h4);
    tick(2);
    chk({fault_led, activity_led}, 2'b11);
    wr(OFS_CTRL, 32'h1);
    adc(6'h20, 8'd100);
    adc(6'h05, 8'd61);
    adc(6'h06, 8'd0);
    rdc(OFS_INPUTS, 32'h60, 32'h20);
    adc(6'h05, 8'd50);
    rdc(OFS_INPUTS, 32'h20, 32'h20);
    adc(6'h05, 8'd39);
    rdc(OFS_INPUTS, 32'h20, 32'h0);
    adc(6'h00, 8'h77);
    rdc(OFS_ANALOG, 32'hff, 32'h77);
    rdc(OFS_FIELD, 32'hff, 32'd100);
    // encoder A on input 16 rises twice, B low: two up counts
    wr(OFS_CTRL, 32'h2);
    for (int i = 0; i < 2; i++) begin
      adc(6'h11, 8'd0);
      adc(6'h10, 8'd17);
      adc(6'h10, 8'd16);
    end
    rdc(OFS_ENCODERS, 32'hffff, 32'h2);
    adc(6'h20, 8'd20);
    rdc(OFS_STATUS, 32'h2, 32'h2);
    wr(OFS_OUTPUTS, 32'hffff);
    short_det <= 16'h0001;
    overtemp_warn <= 2'b10;
    tick(8);
    chk(field_out, 16'h00fe);
    rdc(OFS_STATUS, 32'hc, 32'hc);
    summarize();
  end
endmodule
